// [src/dcbx_pkg.sv]
// Constants and types for the dual-CPU bus extension block.
// Assumes a single design clock; the phase-2 link clock is sampled as data.
package dcbx_pkg;

  // APB register byte offsets
  localparam logic [4:0] DCBX_OFS_BUSCTL = 5'h00;
  localparam logic [4:0] DCBX_OFS_DDATA  = 5'h04;
  localparam logic [4:0] DCBX_OFS_DDIR   = 5'h08;
  localparam logic [4:0] DCBX_OFS_EDATA  = 5'h0C;
  localparam logic [4:0] DCBX_OFS_ADATA  = 5'h10;

  // Bus control field positions
  localparam int DCBX_BC_ACT  = 7;
  localparam int DCBX_BC_P1   = 4;
  localparam int DCBX_BC_NIBH = 3;
  localparam int DCBX_BC_NIBL = 2;
  localparam int DCBX_BC_MODH = 1;
  localparam int DCBX_BC_MODL = 0;

  // Reset value and all-outputs drive enable
  localparam logic [7:0] DCBX_RST_BYTE = 8'h00;
  localparam logic [7:0] DCBX_ALL_OUT  = 8'hFF;

  // Address map
  localparam logic [15:0] DCBX_PA_ADDR  = 16'h0000;
  localparam logic [8:0]  DCBX_RAM_PG0  = 9'h001;
  localparam logic [8:0]  DCBX_RAM_PG1  = 9'h003;
  localparam logic [7:0]  DCBX_STK_PAGE = 8'h01;
  localparam logic [15:0] DCBX_EXT_LO   = 16'h0200;
  localparam logic [15:0] DCBX_EXT_HI   = 16'hEFFF;
  localparam int          DCBX_RAM_N    = 128;

  // Extension width codes
  typedef enum logic [1:0] {
    DCBX_XM_NONE = 2'h0,
    DCBX_XM_8    = 2'h1,
    DCBX_XM_12   = 2'h2,
    DCBX_XM_16   = 2'h3
  } dcbx_xmode_t;

  // Shared port nibble write codes
  localparam logic [1:0] DCBX_NIB_A_BOTH = 2'h0;
  localparam logic [1:0] DCBX_NIB_AH_BL  = 2'h1;
  localparam logic [1:0] DCBX_NIB_AL_BH  = 2'h2;
  localparam logic [1:0] DCBX_NIB_B_BOTH = 2'h3;

  // One CPU access request
  typedef struct packed {
    logic        valid;
    logic        rnw;
    logic        cpuA;
    logic        sync;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dcbx_req_t;

  // APB request
  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [4:0] paddr;
    logic [31:0] pwdata;
  } dcbx_apb_t;

endpackage

// [src/dcbx_bus_ext.sv]
// Bus extension logic: multiplexed low address/data port, upper address
// port, stack page mapping, shared port nibble control, APB registers.
// Assumes the CPU core holds its request until done, and that the phase-2
// clock arrives asynchronously and is far slower than mclk.
//
// Overview of operation
// - Port carries low address then data on the same eight pins.
// - Memory select strobe is low while low address is on the port.
// - Memory select strobe is still produced when port is plain I/O.
// - Bits 1-0 of bus control select none, 8-, 12- or 16-bit extension.
// - In 8-bit mode the upper port keeps its normal output use.
// - In 16-bit mode all upper port pins carry A8 to A15.
// - In 12-bit mode low four upper pins carry A8-A11; rest normal.
// - Phase-2, read/write, fetch and active-CPU signals are driven out.
// - Bit 4 clear: 0180-01FF reaches the same RAM as 0080-00FF.
// - Bit 4 set and extended: 0100-01FF goes to external memory.
// - Bit 7 reads high for first CPU active, low for second.
// - Bits 3-2 choose which CPU writes each shared port nibble.
// - Either CPU may read all eight shared port bits any time.
// - Each CPU may reach 59.5K bytes of external memory map.
`timescale 1ns/10ps

module dcbx_bus_ext
  import dcbx_pkg::*;
#(
  parameter logic [15:0] EXT_END = DCBX_EXT_HI
) (
  // Clock, reset, enable
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       ce,
  // APB slave
  input  wire dcbx_apb_t  apbReq,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  // CPU access port
  input  wire dcbx_req_t  cpuReq,
  output logic [7:0]      cpuRdata,
  output logic            cpuDone,
  // Phase-2 link clock pin
  input  wire logic       phi2Pin,
  // Multiplexed address/data pins
  input  wire logic [7:0] muxAddrDataIn,
  output logic [7:0]      muxAddrDataOut,
  output logic [7:0]      muxAddrDataOe,
  // Upper address pins
  output logic [7:0]      upperAddressOut,
  // Bus control pins
  output logic            extMemSelectN,
  output logic            phi2Out,
  output logic            rnwOut,
  output logic            syncOut,
  output logic            cpuAActiveOut,
  // Shared general port pins
  output logic [7:0]      sharedGeneralPortOut
);

  if (EXT_END <= DCBX_EXT_LO) begin : gChk
    $error("EXT_END must lie above the external base");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ADDR, ST_DATA} dcbx_st_t;

  typedef struct packed {
    dcbx_st_t                      st;
    dcbx_xmode_t                   mode;
    logic                          p1Ext;
    logic [1:0]                    nib;
    logic [7:0]                    ddata;
    logic [7:0]                    ddir;
    logic [7:0]                    edata;
    logic [7:0]                    adata;
    logic [DCBX_RAM_N-1:0][7:0]    ram;
    logic                          phiS1;
    logic                          phiS2;
    logic                          phiPrev;
    logic [7:0]                    mdS1;
    logic [7:0]                    mdS2;
    logic [15:0]                   addr;
    logic [7:0]                    wdata;
    logic                          rnw;
    logic [31:0]                   prdata;
    logic                          pready;
    logic                          pslverr;
    logic [7:0]                    rdata;
    logic                          done;
    logic [7:0]                    muxOut;
    logic [7:0]                    muxOe;
    logic [7:0]                    upper;
    logic                          emsN;
    logic                          phi2O;
    logic                          rnwO;
    logic                          syncO;
    logic                          actO;
  } dcbx_state_t;

  dcbx_state_t cur_ff;
  dcbx_state_t nxt_ff;

  // Which nibbles (hi, lo) the given CPU may write
  function automatic logic [1:0] nibMask(input logic [1:0] code,
                                         input logic       isA);
    logic [1:0] m;
    m = 2'b00;
    case (code)
      DCBX_NIB_A_BOTH: m = isA ? 2'b11 : 2'b00;
      DCBX_NIB_AH_BL:  m = isA ? 2'b10 : 2'b01;
      DCBX_NIB_AL_BH:  m = isA ? 2'b01 : 2'b10;
      DCBX_NIB_B_BOTH: m = isA ? 2'b00 : 2'b11;
      default:         m = 2'b00;
    endcase
    return m;
  endfunction

  // Write selected nibbles of a byte
  function automatic logic [7:0] nibWrite(input logic [7:0] old,
                                          input logic [7:0] val,
                                          input logic [1:0] m);
    logic [7:0] r;
    r = old;
    if (m[1]) begin
      r[7:4] = val[7:4];
    end
    if (m[0]) begin
      r[3:0] = val[3:0];
    end
    return r;
  endfunction

  // Bus control byte as software reads it
  function automatic logic [7:0] busCtl(input dcbx_state_t s);
    logic [7:0] b;
    b = DCBX_RST_BYTE;
    b[DCBX_BC_ACT] = s.actO;
    b[DCBX_BC_P1] = s.p1Ext;
    b[DCBX_BC_NIBH:DCBX_BC_NIBL] = s.nib;
    b[DCBX_BC_MODH:DCBX_BC_MODL] = s.mode;
    return b;
  endfunction

  // APB access phase present on the bus
  function automatic logic apbAccess(input dcbx_apb_t r);
    return r.psel && r.penable;
  endfunction

  logic       extended;
  logic       inRam;
  logic [6:0] ramIdx;
  logic       isExt;
  logic       apbHit;
  logic       apbDo;
  logic       phiRise;
  logic       phiFall;

  // Address decode of the pending CPU request
  always_comb begin
    extended = (cur_ff.mode != DCBX_XM_NONE);
    ramIdx = cpuReq.addr[6:0];
    // Page one aliases page zero RAM unless mapped out
    inRam = (cpuReq.addr[15:7] == DCBX_RAM_PG0)
            || ((cpuReq.addr[15:7] == DCBX_RAM_PG1)
                && !(cur_ff.p1Ext && extended));
    // Stack page leaves the chip only when mapped out and extended
    isExt = ((cpuReq.addr >= DCBX_EXT_LO) && (cpuReq.addr <= EXT_END))
            || ((cpuReq.addr[15:8] == DCBX_STK_PAGE)
                && cur_ff.p1Ext && extended);
    // Edges of the synchronised phase-2 clock
    phiRise = cur_ff.phiS2 && !cur_ff.phiPrev;
    phiFall = !cur_ff.phiS2 && cur_ff.phiPrev;
    apbHit = (apbReq.paddr == DCBX_OFS_BUSCTL) || (apbReq.paddr == DCBX_OFS_DDATA)
             || (apbReq.paddr == DCBX_OFS_DDIR) || (apbReq.paddr == DCBX_OFS_EDATA)
             || (apbReq.paddr == DCBX_OFS_ADATA);
    // Write lands only at the edge that samples pready high
    apbDo = apbAccess(apbReq) && cur_ff.pready;
  end

  // Next state
  always_comb begin
    nxt_ff = cur_ff;
    // Two-stage pin synchronisers
    nxt_ff.phiS1 = phi2Pin;
    nxt_ff.phiS2 = cur_ff.phiS1;
    nxt_ff.phiPrev = cur_ff.phiS2;
    nxt_ff.mdS1 = muxAddrDataIn;
    nxt_ff.mdS2 = cur_ff.mdS1;
    // Debug and control outputs follow the core
    nxt_ff.phi2O = cur_ff.phiS2;
    nxt_ff.actO = cpuReq.cpuA;
    // Done is a one-cycle pulse
    nxt_ff.done = 1'b0;

    // APB: answer one cycle into the access phase
    nxt_ff.pready = apbAccess(apbReq) && !cur_ff.pready;
    // Unmapped offsets answer with an error and drop writes
    nxt_ff.pslverr = nxt_ff.pready && !apbHit;
    nxt_ff.prdata = '0;
    if (nxt_ff.pready && !apbReq.pwrite) begin
      case (apbReq.paddr)
        DCBX_OFS_BUSCTL: nxt_ff.prdata[7:0] = busCtl(cur_ff);
        DCBX_OFS_DDATA:  nxt_ff.prdata[7:0] = cur_ff.ddata;
        DCBX_OFS_DDIR:   nxt_ff.prdata[7:0] = cur_ff.ddir;
        DCBX_OFS_EDATA:  nxt_ff.prdata[7:0] = cur_ff.edata;
        DCBX_OFS_ADATA:  nxt_ff.prdata[7:0] = cur_ff.adata;
        default:         nxt_ff.prdata = '0;
      endcase
    end
    if (apbDo && apbReq.pwrite) begin
      case (apbReq.paddr)
        DCBX_OFS_BUSCTL: begin
          nxt_ff.mode = dcbx_xmode_t'(apbReq.pwdata[DCBX_BC_MODH:DCBX_BC_MODL]);
          nxt_ff.p1Ext = apbReq.pwdata[DCBX_BC_P1];
          nxt_ff.nib = apbReq.pwdata[DCBX_BC_NIBH:DCBX_BC_NIBL];
        end
        DCBX_OFS_DDATA: nxt_ff.ddata = apbReq.pwdata[7:0];
        DCBX_OFS_DDIR:  nxt_ff.ddir = apbReq.pwdata[7:0];
        DCBX_OFS_EDATA: nxt_ff.edata = apbReq.pwdata[7:0];
        default:        nxt_ff.ddata = cur_ff.ddata;
      endcase
    end

    // CPU access sequencing
    case (cur_ff.st)
      ST_IDLE: begin
        // Done guard keeps a still-held request from running twice
        if (cpuReq.valid && !cur_ff.done) begin
          nxt_ff.addr = cpuReq.addr;
          nxt_ff.wdata = cpuReq.wdata;
          nxt_ff.rnw = cpuReq.rnw;
          if (isExt) begin
            nxt_ff.st = ST_WAIT;
          end else begin
            // Internal targets answer at once
            nxt_ff.done = 1'b1;
            // Unmapped internal space reads as zero
            nxt_ff.rdata = DCBX_RST_BYTE;
            if (cpuReq.addr == DCBX_PA_ADDR) begin
              if (cpuReq.rnw) begin
                nxt_ff.rdata = cur_ff.adata;
              end else begin
                nxt_ff.adata = nibWrite(cur_ff.adata, cpuReq.wdata,
                                        nibMask(cur_ff.nib, cpuReq.cpuA));
              end
            end else if (inRam) begin
              if (cpuReq.rnw) begin
                nxt_ff.rdata = cur_ff.ram[ramIdx];
              end else begin
                nxt_ff.ram[ramIdx] = cpuReq.wdata;
              end
            end
          end
        end
      end
      ST_WAIT: begin
        // Address phase starts as phase 2 falls
        if (phiFall) begin
          nxt_ff.st = ST_ADDR;
          nxt_ff.emsN = 1'b0;
          // Control lines move with the strobe for the latches
          nxt_ff.rnwO = cur_ff.rnw;
          nxt_ff.syncO = cpuReq.sync;
        end
      end
      ST_ADDR: begin
        // Data phase while phase 2 is high
        if (phiRise) begin
          nxt_ff.st = ST_DATA;
          nxt_ff.emsN = 1'b1;
        end
      end
      ST_DATA: begin
        if (phiFall) begin
          nxt_ff.st = ST_IDLE;
          nxt_ff.done = 1'b1;
          // Pins lag two cycles; the data phase is longer than that
          nxt_ff.rdata = (cur_ff.rnw && extended) ? cur_ff.mdS2 : DCBX_RST_BYTE;
          nxt_ff.rnwO = 1'b1;
          nxt_ff.syncO = 1'b0;
        end
      end
      default: nxt_ff.st = ST_IDLE;
    endcase

    // Multiplexed port: bus owns it when extended, else plain I/O
    // Direction register is ignored while extended so it cannot
    // fight the external address latch
    if (!extended) begin
      nxt_ff.muxOut = cur_ff.ddata;
      nxt_ff.muxOe = cur_ff.ddir;
    end else if (nxt_ff.st == ST_ADDR) begin
      nxt_ff.muxOut = cur_ff.addr[7:0];
      nxt_ff.muxOe = DCBX_ALL_OUT;
    end else if (nxt_ff.st == ST_DATA && !cur_ff.rnw) begin
      nxt_ff.muxOut = cur_ff.wdata;
      nxt_ff.muxOe = DCBX_ALL_OUT;
    end else begin
      nxt_ff.muxOut = cur_ff.ddata;
      nxt_ff.muxOe = DCBX_RST_BYTE;
    end

    // Upper port by extension width
    case (cur_ff.mode)
      DCBX_XM_16: nxt_ff.upper = cur_ff.addr[15:8];
      DCBX_XM_12: nxt_ff.upper = {cur_ff.edata[7:4], cur_ff.addr[11:8]};
      // Pins not claimed by the bus keep the output register
      default:    nxt_ff.upper = cur_ff.edata;
    endcase
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      // Strobe and read line rest high, all else clears
      cur_ff <= '0;
      cur_ff.st <= ST_IDLE;
      cur_ff.mode <= DCBX_XM_NONE;
      cur_ff.emsN <= 1'b1;
      cur_ff.rnwO <= 1'b1;
    end else if (ce) begin
      cur_ff <= nxt_ff;
    end
  end

  // Outputs straight from the state register
  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign cpuRdata = cur_ff.rdata;
  assign cpuDone = cur_ff.done;
  assign muxAddrDataOut = cur_ff.muxOut;
  assign muxAddrDataOe = cur_ff.muxOe;
  assign upperAddressOut = cur_ff.upper;
  assign extMemSelectN = cur_ff.emsN;
  assign phi2Out = cur_ff.phi2O;
  assign rnwOut = cur_ff.rnwO;
  assign syncOut = cur_ff.syncO;
  assign cpuAActiveOut = cur_ff.actO;
  assign sharedGeneralPortOut = cur_ff.adata;

endmodule

// [testbench/dcbx_bus_ext_asserts.sv]
// Checker for the bus extension block, bound to its top module.
// Assumes ce stays high whenever the block is checked.
`timescale 1ns/10ps
module dcbx_bus_ext_asserts
  import dcbx_pkg::*;
(
  // Clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // Requests and answers
  input wire dcbx_apb_t   apbReq,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire dcbx_req_t   cpuReq,
  input wire logic        cpuDone,
  // Pins
  input wire logic        phi2Pin,
  input wire logic [7:0]  muxAddrDataOut,
  input wire logic [7:0]  muxAddrDataOe,
  input wire logic        extMemSelectN,
  input wire logic        phi2Out,
  input wire logic        rnwOut,
  input wire logic        syncOut,
  input wire logic        cpuAActiveOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // Address phase and control pins
  a_addr_low: assert property (!extMemSelectN && muxAddrDataOe == 8'hFF
    |-> muxAddrDataOut == cpuReq.addr[7:0]) else $error("low address lost");
  a_strobe_req: assert property (!extMemSelectN |-> cpuReq.valid)
    else $error("strobe without access");
  a_rnw_write: assert property (!rnwOut |-> cpuReq.valid && !cpuReq.rnw)
    else $error("write line wrong");
  a_phi_follow: assert property ($rose(phi2Pin) |-> ##[1:4] $rose(phi2Out))
    else $error("phase-2 copy late");
  a_sync_copy: assert property (!extMemSelectN |-> syncOut == cpuReq.sync)
    else $error("fetch flag wrong");
  a_act_copy: assert property (cpuReq.valid |=> cpuAActiveOut == $past(cpuReq.cpuA))
    else $error("active cpu wrong");
  // Register bus and completion
  a_apb_ready: assert property (apbReq.psel && $rose(apbReq.penable) |=> pready)
    else $error("ready late");
  a_err_map: assert property (pready |-> pslverr ==
    (apbReq.paddr > 5'h10 || apbReq.paddr[1:0] != 2'h0)) else $error("error flag wrong");
  a_done_pulse: assert property (cpuDone |=> !cpuDone)
    else $error("done too long");
endmodule

bind dcbx_bus_ext dcbx_bus_ext_asserts dcbx_bus_ext_asserts_inst (
  .mclk(mclk), .rst(rst), .apbReq(apbReq), .pready(pready), .pslverr(pslverr),
  .cpuReq(cpuReq), .cpuDone(cpuDone), .phi2Pin(phi2Pin),
  .muxAddrDataOut(muxAddrDataOut), .muxAddrDataOe(muxAddrDataOe),
  .extMemSelectN(extMemSelectN), .phi2Out(phi2Out), .rnwOut(rnwOut),
  .syncOut(syncOut), .cpuAActiveOut(cpuAActiveOut));

// [testbench/dcbx_ext_mem.sv]
// External memory with a low address latch on the multiplexed port.
// Assumes the bench resolves the port pins from the device drive enable alone.
`timescale 1ns/10ps
module dcbx_ext_mem (
  // Clock
  input  wire logic       mclk,
  // Bus control from the device
  input  wire logic       extMemSelectN,
  input  wire logic       rnwOut,
  input  wire logic       phi2Out,
  input  wire logic [7:0] muxAddrDataOut,
  input  wire logic [7:0] muxAddrDataOe,
  // Value put on the port pins
  output logic [7:0]      memDrive
);
  logic [7:0] mem [0:255];
  logic [7:0] lat;
  logic [7:0] last = 8'h00;
  logic       act = 1'b0;
  logic       phiQ = 1'b0;
  logic       rdOn;
  assign rdOn = act && extMemSelectN && rnwOut;
  // Latch address, store writes, end cycle on phase-2 fall
  always @(posedge mclk) begin
    phiQ <= phi2Out;
    if (!extMemSelectN) begin
      lat <= muxAddrDataOut;
      act <= 1'b1;
    end else if (phiQ && !phi2Out) begin
      act <= 1'b0;
    end
    if (act && extMemSelectN && !rnwOut && muxAddrDataOe == 8'hFF) mem[lat] <= muxAddrDataOut;
    if (rdOn) last <= mem[lat];
  end
  // Read data, else inverse of last value
  assign memDrive = rdOn ? mem[lat] : ~last;
endmodule

// [testbench/dual_cpu_bus_extension_bench.sv]
// Self-checking bench for the bus extension block.
// Assumes the memory model and checker compile before it.
`timescale 1ns/10ps
module dual_cpu_bus_extension_bench;
  import dcbx_pkg::*;
  logic        mclk, rst, phi2Pin, pready, pslverr, cpuDone, extMemSelectN;
  logic        phi2Out, rnwOut, syncOut, cpuAActiveOut, err, sawSel;
  dcbx_apb_t   apbReq;
  dcbx_req_t   cpuReq;
  logic [31:0] prdata, rd;
  logic [7:0]  cpuRdata, muxOut, muxOe, memDrive, pins, upperOut, portOut, seenHi, seenLo;
  int          fails, n_checks, cyc;
  // Pin level from both drivers
  assign pins = (muxOe & muxOut) | (~muxOe & memDrive);
  dcbx_bus_ext dcbx_bus_ext_inst (.mclk(mclk), .rst(rst), .ce(1'b1), .apbReq(apbReq),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpuReq(cpuReq),
    .cpuRdata(cpuRdata), .cpuDone(cpuDone), .phi2Pin(phi2Pin), .muxAddrDataIn(pins),
    .muxAddrDataOut(muxOut), .muxAddrDataOe(muxOe), .upperAddressOut(upperOut),
    .extMemSelectN(extMemSelectN), .phi2Out(phi2Out), .rnwOut(rnwOut),
    .syncOut(syncOut), .cpuAActiveOut(cpuAActiveOut), .sharedGeneralPortOut(portOut));
  dcbx_ext_mem dcbx_ext_mem_inst (.mclk(mclk), .extMemSelectN(extMemSelectN),
    .rnwOut(rnwOut), .phi2Out(phi2Out), .muxAddrDataOut(muxOut),
    .muxAddrDataOe(muxOe), .memDrive(memDrive));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %0t %s got %h", $time, msg, got);
    end
  endtask
  // One APB transfer, then one idle edge
  task automatic apb(input logic wr, input logic [4:0] a, input logic [7:0] d);
    int n;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      fails++;
      $display("mismatch %0t apb no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
    @(posedge mclk);
  endtask
  // One CPU access, noting the address phase
  task automatic cpu(input logic a, input logic r, input logic [15:0] ad, input logic [7:0] d);
    int n;
    cpuReq <= '{valid: 1'b1, rnw: r, cpuA: a, sync: r, addr: ad, wdata: d};
    sawSel = 0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
      if (extMemSelectN === 1'b0) begin
        sawSel = 1;
        seenHi = upperOut;
        seenLo = muxOut;
      end
    end while (cpuDone !== 1'b1 && n < 200);
    if (cpuDone !== 1'b1) begin
      fails++;
      $display("mismatch %0t cpu no done", $time);
    end
    cpuReq.valid <= 1'b0;
    @(posedge mclk);
  endtask
  // Idle state after reset, unmapped offset error and plain I/O port use
  task automatic t_reset;
    chk(extMemSelectN, 1, "strobe idle");
    apb(0, DCBX_OFS_BUSCTL, 0);
    chk(rd, 0, "ctl reset");
    apb(0, 5'h14, 0);
    chk(err, 1, "unmapped");
    apb(1, DCBX_OFS_DDATA, 8'h3C);
    apb(1, DCBX_OFS_DDIR, 8'hF0);
    cpu(1, 0, 16'h0300, 8'h11);
    chk(sawSel, 1, "gpio strobe");
    chk(seenLo, 8'h3C, "gpio data");
    chk(muxOe, 8'hF0, "gpio dir");
    apb(0, DCBX_OFS_DDATA, 0);
    chk(rd, 8'h3C, "gpio reg");
    apb(1, DCBX_OFS_DDIR, 8'h00);
    apb(0, DCBX_OFS_DDIR, 0);
    chk(rd, 0, "dir clear");
    chk(muxOe, 8'h00, "port released");
  endtask
  // Every width code, port direction left cleared
  task automatic t_modes;
    logic [7:0] ex;
    apb(1, DCBX_OFS_EDATA, 8'hA5);
    for (int m = 0; m < 4; m++) begin
      apb(1, DCBX_OFS_BUSCTL, m[7:0]);
      cpu(1, 0, 16'hEF5A, 8'h60 + m[7:0]);
      ex = m == 3 ? 8'hEF : (m == 2 ? 8'hAF : 8'hA5);
      chk(sawSel, 1, "strobe");
      chk(seenHi, ex, "upper");
      if (m != 0) chk(seenLo, 8'h5A, "low addr");
      cpu(1, 1, 16'hEF5A, 0);
      chk(cpuRdata, m == 0 ? 8'h00 : 8'h60 + m[7:0], "read back");
    end
  endtask
  // Page one mapping and active CPU bit
  task automatic t_stack;
    apb(1, DCBX_OFS_BUSCTL, 8'h03);
    cpu(1, 0, 16'h0085, 8'h3C);
    cpu(0, 1, 16'h0185, 0);
    chk(cpuRdata, 8'h3C, "alias");
    chk(sawSel, 0, "alias inside");
    apb(1, DCBX_OFS_BUSCTL, 8'hF3);
    apb(0, DCBX_OFS_BUSCTL, 0);
    chk(rd, 8'h13, "ctl b");
    cpu(0, 0, 16'h0185, 8'hC3);
    chk(sawSel, 1, "stack out");
    cpu(1, 1, 16'h0085, 0);
    chk(cpuRdata, 8'h3C, "page zero");
    apb(0, DCBX_OFS_BUSCTL, 0);
    chk(rd, 8'h93, "ctl a");
    cpu(1, 1, 16'hF000, 0);
    chk(sawSel, 0, "top inside");
  endtask
  // Nibble ownership of the shared port
  task automatic t_nibble;
    logic [7:0] ma;
    for (int c = 0; c < 4; c++) begin
      ma = c == 0 ? 8'hFF : (c == 1 ? 8'hF0 : (c == 2 ? 8'h0F : 8'h00));
      apb(1, DCBX_OFS_BUSCTL, 8'h03);
      cpu(1, 0, DCBX_PA_ADDR, 8'h00);
      apb(1, DCBX_OFS_BUSCTL, {4'h0, c[1:0], 2'h3});
      cpu(1, 0, DCBX_PA_ADDR, 8'hFF);
      chk(portOut, ma, "nibble a");
      cpu(0, 1, DCBX_PA_ADDR, 0);
      chk(cpuRdata, ma, "port read");
      cpu(0, 0, DCBX_PA_ADDR, 8'hFF);
      chk(portOut, 8'hFF, "nibble b");
    end
    apb(0, DCBX_OFS_ADATA, 0);
    chk(rd, 8'hFF, "port apb");
  endtask
  // Verdict and end of run
  task automatic wrap_up;
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Clocks
  initial begin
    mclk = 0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    phi2Pin = 0;
    #37;
    forever #200 phi2Pin = ~phi2Pin;
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      wrap_up;
    end
  end
  // Main sequence
  initial begin
    rst = 1;
    apbReq = '0;
    cpuReq = '0;
    repeat (8) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    t_reset;
    t_modes;
    t_stack;
    t_nibble;
    wrap_up;
  end
endmodule
